/* hdl/agc_flag_driver_regs.sv */
// agc debounce, adc flag, dac power and high-power driver register bank
// What this block does
// - noise debounce code to 0..1536 ms
// - signal debounce code to 0..32 ms
// - double rate mode changes debounce times
// - adc power flags at bits 6, 2
// - below-threshold flags at bits 5, 1
// - agc at maximum gain flags at 4, 0
// - bits 7, 6 power left, right dac
// - left common output mode, two bits
// - right common output mode, three bits
// - bit 2 enables short protection everywhere
// - bit 1 picks current limit or shutdown
// - debounce register at offset 35
`timescale 1ns/1ps
module agc_flag_driver_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
    parameter int unsigned HALF_MS_CYCLES = agc_regs_pkg::HALF_MS_CYCLES_DEF
) (
    // clock and reset
    input logic mclk,
    input logic rst_n,
    // control bus pins
    input logic scl_i,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // left channel status from the record path
    input logic left_gain_settled,
    input logic left_adc_powered,
    input logic left_below_noise,
    input logic left_agc_at_max,
    // right channel status from the record path
    input logic right_gain_settled,
    input logic right_adc_powered,
    input logic right_below_noise,
    input logic right_agc_at_max,
    // sample rate mode
    input logic double_rate_mode,
    // dac power
    output logic left_dac_power_en,
    output logic right_dac_power_en,
    // headphone common terminal modes
    output logic [1:0] left_common_out_mode,
    output logic [2:0] right_common_out_mode,
    // short-circuit protection
    output logic short_protect_en,
    output logic short_current_limit,
    output logic short_auto_shutdown
);
    import agc_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    // number of synchronised status inputs
    localparam int NSYNC = 9;

    // whole state of the bank
    typedef struct packed {
        logic [NSYNC-1:0] meta; // first sync stage
        logic [NSYNC-1:0] sync; // second sync stage
        logic [7:0] debounce;
        logic [7:0] dac;
        logic [7:0] hpd;
        logic [agc_regs_pkg::TICK_W-1:0] tick_cnt;
        logic tick;
    } bank_t;

    bank_t q, d;

    // register port wires
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    // right quiet flag after debounce
    logic right_quiet;

    // tick period for the current rate
    logic [TICK_W-1:0] tick_limit;

    // flag register contents
    logic [7:0] flags;

    // status inputs in flag-bit order, rate mode on top
    logic [NSYNC-1:0] status_raw;
    assign status_raw = {double_rate_mode,
                         left_gain_settled, left_adc_powered,
                         left_below_noise, left_agc_at_max,
                         right_gain_settled, right_adc_powered,
                         right_below_noise, right_agc_at_max};

    ////////////////////////////////////////////////////////////////////////
    // control bus

    // i2c target with auto-incrementing pointer
    i2c_reg_port #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // debounce timing

    // rate halves ticks
    // double rate runs the detector twice as fast, so every wait halves
    assign tick_limit = q.sync[NSYNC-1] ? TICK_W'(HALF_MS_CYCLES / 2)
                                        : TICK_W'(HALF_MS_CYCLES);

    agc_debounce u_debounce (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(q.tick),
        .noise_code(q.debounce[NOISE_DB_LSB +: 5]),
        .sig_code(q.debounce[SIG_DB_LSB +: 3]),
        .raw_quiet(q.sync[FLG_R_QUIET]),
        .quiet(right_quiet)
    );

    ////////////////////////////////////////////////////////////////////////
    // flag register

    // status flag bits
    // right quiet bit comes from the debouncer, the rest straight through
    assign flags = {q.sync[7:2], right_quiet, q.sync[0]};

    ////////////////////////////////////////////////////////////////////////
    // next state

    // sync, tick and register writes
    always_comb begin
        d = q;
        // two-stage synchronisers for status from other logic
        d.meta = status_raw;
        d.sync = q.meta;
        // half-ms tick
        d.tick = 1'b0;
        if (q.tick_cnt >= tick_limit - TICK_W'(1)) begin
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + TICK_W'(1);
        end
        // host writes
        if (wr_stb) begin
            unique case (wr_addr)
                DEBOUNCE_OFF: begin
                    d.debounce = wr_data;
                end
                DAC_OFF: begin
                    d.dac = wr_data & DAC_WMASK;
                end
                HPD_OFF: begin
                    d.hpd = wr_data & HPD_WMASK;
                end
                // flags read-only
                // flag register and unmapped addresses ignore writes
                default: begin
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q.meta <= '0;
            q.sync <= '0;
            q.debounce <= DEBOUNCE_RST;
            q.dac <= DAC_RST;
            q.hpd <= HPD_RST;
            q.tick_cnt <= '0;
            q.tick <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    // read mux; unmapped addresses read zero
    always_comb begin
        unique case (rd_addr)
            DEBOUNCE_OFF: begin
                rd_data = q.debounce;
            end
            FLAGS_OFF: begin
                rd_data = flags;
            end
            DAC_OFF: begin
                rd_data = q.dac;
            end
            HPD_OFF: begin
                rd_data = q.hpd;
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // dac power enables
    assign left_dac_power_en = q.dac[DAC_LEFT_BIT];
    assign right_dac_power_en = q.dac[DAC_RIGHT_BIT];

    // common terminal modes
    assign left_common_out_mode = q.dac[LCOM_LSB +: 2];
    assign right_common_out_mode = q.hpd[RCOM_LSB +: 3];

    assign short_protect_en = q.hpd[SC_EN_BIT];

    // action select
    // action only means anything while protection is on
    assign short_current_limit = q.hpd[SC_EN_BIT] & ~q.hpd[SC_MODE_BIT];
    assign short_auto_shutdown = q.hpd[SC_EN_BIT] & q.hpd[SC_MODE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // host write to a given register
    sequence wr_dac_s;
        wr_stb && wr_addr == DAC_OFF;
    endsequence

    sequence wr_hpd_s;
        wr_stb && wr_addr == HPD_OFF;
    endsequence

    sequence wr_db_s;
        wr_stb && wr_addr == DEBOUNCE_OFF;
    endsequence

    AST_DRA_TICK: assert property (q.tick |->
        $past(q.tick_cnt) >= $past(tick_limit) - TICK_W'(1))
        else $error("tick period does not follow rate mode");
    AST_GAIN_FLAGS: assert property (##2 flags[7] == $past(left_gain_settled, 2)
        && flags[3] == $past(right_gain_settled, 2))
        else $error("gain status flag wrong");
    AST_POWER_FLAGS: assert property (##2 flags[6] == $past(left_adc_powered, 2)
        && flags[2] == $past(right_adc_powered, 2))
        else $error("adc power flag wrong");
    AST_QUIET_FLAGS: assert property (##2 flags[5] == $past(left_below_noise, 2)
        && (!$changed(flags[1]) || flags[1] == $past(q.sync[FLG_R_QUIET])))
        else $error("signal detection flag wrong");
    AST_SAT_FLAGS: assert property (##2 flags[4] == $past(left_agc_at_max, 2)
        && flags[0] == $past(right_agc_at_max, 2))
        else $error("saturation flag wrong");
    AST_DAC_POWER: assert property (wr_dac_s |=>
        left_dac_power_en == $past(wr_data[7]) && right_dac_power_en == $past(wr_data[6]))
        else $error("dac power enable did not follow write");
    AST_LCOM_MODE: assert property (wr_dac_s |=>
        left_common_out_mode == $past(wr_data[5:4]))
        else $error("left common mode did not follow write");
    AST_RCOM_MODE: assert property (wr_hpd_s |=>
        right_common_out_mode == $past(wr_data[5:3]))
        else $error("right common mode did not follow write");
    AST_SC_ENABLE: assert property (wr_hpd_s |=>
        short_protect_en == $past(wr_data[2]))
        else $error("protection enable did not follow write");
    AST_SC_ACTION: assert property ((short_current_limit || short_auto_shutdown) |->
        short_protect_en && (short_current_limit != short_auto_shutdown))
        else $error("protection action without enable");
    AST_DB_REG: assert property (wr_db_s |=>
        q.debounce == $past(wr_data) && $past(wr_addr) == 8'h23)
        else $error("debounce register did not follow write");
    AST_RESERVED: assert property (q.dac[3:0] == 4'h0
        && q.hpd[7:6] == 2'h0 && q.hpd[0] == 1'b0)
        else $error("reserved bits took a written value");

endmodule

/* hdl/agc_regs_pkg.sv */
// shared constants and types for the agc flag and driver configuration bank
package agc_regs_pkg;

    // register offsets on page 0
    localparam logic [7:0] DEBOUNCE_OFF = 8'h23;
    localparam logic [7:0] FLAGS_OFF = 8'h24;
    localparam logic [7:0] DAC_OFF = 8'h25;
    localparam logic [7:0] HPD_OFF = 8'h26;

    // reset values, all registers clear to zero
    localparam logic [7:0] DEBOUNCE_RST = 8'h00;
    localparam logic [7:0] DAC_RST = 8'h00;
    localparam logic [7:0] HPD_RST = 8'h00;

    // writable bits; reserved bits are dropped on write
    localparam logic [7:0] DAC_WMASK = 8'hF0;
    localparam logic [7:0] HPD_WMASK = 8'h3E;

    // debounce register fields
    localparam int NOISE_DB_LSB = 3;
    localparam int SIG_DB_LSB = 0;

    // dac power and left common output fields
    localparam int DAC_LEFT_BIT = 7;
    localparam int DAC_RIGHT_BIT = 6;
    localparam int LCOM_LSB = 4;

    // high-power driver fields
    localparam int RCOM_LSB = 3;
    localparam int SC_EN_BIT = 2;
    localparam int SC_MODE_BIT = 1;

    // flag register bit positions
    localparam int FLG_R_QUIET = 1;

    // timing: debounce is counted in half-millisecond ticks
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYCLES_DEF = HALF_MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 17;
    localparam int DB_W = 12;
    localparam logic [DB_W-1:0] LONG_STEP_HALFMS = 12'h080;
    localparam logic [4:0] SHORT_CODES = 5'h08;

    // bus port states
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_WBYTE, I2C_WACK, I2C_RBYTE, I2C_RACK
    } i2c_state_t;

    // debounce code to length in half-ms ticks
    function automatic logic [DB_W-1:0] debounce_halfms(input logic [4:0] code);
        logic [DB_W-1:0] len;
        len = '0;
        if (code == 5'h00) begin
            len = '0;
        end else if (code < SHORT_CODES) begin
            len = DB_W'(12'h001 << (code - 5'h01));
        end else begin
            len = DB_W'(LONG_STEP_HALFMS * DB_W'(code - 5'h07));
        end
        return len;
    endfunction

endpackage

/* hdl/i2c_reg_port.sv */
// i2c target that turns bus transfers into register reads and writes
`timescale 1ns/1ps
module i2c_reg_port #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    // clock and reset
    input logic mclk,
    input logic rst_n,
    // bus pins
    input logic scl_i,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // register side
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] rd_addr,
    input logic [7:0] rd_data
);
    import agc_regs_pkg::*;

    // whole state of the port
    typedef struct packed {
        logic [2:0] scl_sh; // [0] first sync flop, [2] delayed copy
        logic [2:0] sda_sh;
        agc_regs_pkg::i2c_state_t st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic first;
        logic ack;
        logic drive;
        logic stb;
        logic [7:0] waddr;
        logic [7:0] wdata;
    } port_t;

    port_t q, d;

    // next state
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise = q.scl_sh[1] & ~q.scl_sh[2];
        fall = ~q.scl_sh[1] & q.scl_sh[2];
        start = q.scl_sh[1] & q.scl_sh[2] & q.sda_sh[2] & ~q.sda_sh[1];
        stop = q.scl_sh[1] & q.scl_sh[2] & ~q.sda_sh[2] & q.sda_sh[1];
        d = q;
        d.stb = 1'b0;
        d.scl_sh = {q.scl_sh[1:0], scl_i};
        d.sda_sh = {q.sda_sh[1:0], sda_i};
        if (start) begin
            // start or repeated start: address byte follows
            d.st = I2C_ADDR;
            d.bits = 4'h0;
            d.first = 1'b1;
            d.drive = 1'b0;
        end else if (stop) begin
            d.st = I2C_IDLE;
            d.drive = 1'b0;
        end else if (rise) begin
            // sample incoming bits on scl high
            if (q.st == I2C_ADDR || q.st == I2C_WBYTE) begin
                d.sh = {q.sh[6:0], q.sda_sh[1]};
                d.bits = q.bits + 4'h1;
            end
            if (q.st == I2C_RACK) begin
                d.ack = ~q.sda_sh[1];
            end
        end else if (fall) begin
            // change sda only while scl is low
            unique case (q.st)
                I2C_IDLE: begin
                end
                I2C_ADDR: begin
                    if (q.bits == 4'h8) begin
                        if (q.sh[7:1] == DEV_ADDR) begin
                            d.st = I2C_ADDR_ACK;
                            d.drive = 1'b1;
                        end else begin
                            d.st = I2C_IDLE;
                        end
                    end
                end
                I2C_ADDR_ACK: begin
                    d.bits = 4'h0;
                    if (q.sh[0]) begin
                        d.st = I2C_RBYTE;
                        d.sh = rd_data;
                        d.drive = ~rd_data[7];
                    end else begin
                        d.st = I2C_WBYTE;
                        d.drive = 1'b0;
                    end
                end
                I2C_WBYTE: begin
                    if (q.bits == 4'h8) begin
                        d.st = I2C_WACK;
                        d.drive = 1'b1;
                        if (q.first) begin
                            // first byte after address sets the pointer
                            d.ptr = q.sh;
                            d.first = 1'b0;
                        end else begin
                            d.stb = 1'b1;
                            d.waddr = q.ptr;
                            d.wdata = q.sh;
                            d.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                I2C_WACK: begin
                    d.st = I2C_WBYTE;
                    d.bits = 4'h0;
                    d.drive = 1'b0;
                end
                I2C_RBYTE: begin
                    if (q.bits == 4'h7) begin
                        d.st = I2C_RACK;
                        d.drive = 1'b0;
                        d.ptr = q.ptr + 8'h01;
                    end else begin
                        d.bits = q.bits + 4'h1;
                        d.sh = {q.sh[6:0], 1'b0};
                        d.drive = ~q.sh[6];
                    end
                end
                I2C_RACK: begin
                    // controller ack asks for the next byte
                    if (q.ack) begin
                        d.st = I2C_RBYTE;
                        d.bits = 4'h0;
                        d.sh = rd_data;
                        d.drive = ~rd_data[7];
                    end else begin
                        d.st = I2C_IDLE;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '0;
            // pins idle high, so no false edge is seen after reset
            q.scl_sh <= 3'b111;
            q.sda_sh <= 3'b111;
        end else begin
            q <= d;
        end
    end

    // open-drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = q.drive;
    assign wr_stb = q.stb;
    assign wr_addr = q.waddr;
    assign wr_data = q.wdata;
    assign rd_addr = q.ptr;

endmodule

/* hdl/agc_debounce.sv */
// debounced quiet flag for the right agc signal detector
`timescale 1ns/1ps
module agc_debounce (
    // clock and reset
    input logic mclk,
    input logic rst_n,
    // timing and settings
    input logic tick,
    input logic [4:0] noise_code,
    input logic [2:0] sig_code,
    // detector
    input logic raw_quiet,
    output logic quiet
);
    import agc_regs_pkg::*;

    // flag and tick counter
    typedef struct packed {
        logic flag;
        logic [agc_regs_pkg::DB_W-1:0] cnt;
    } db_t;

    db_t q, d;

    // wait length for the pending change
    logic [DB_W-1:0] target;
    assign target = raw_quiet ? debounce_halfms(noise_code)
                              : debounce_halfms({2'b00, sig_code});

    // next state
    always_comb begin
        d = q;
        if (raw_quiet == q.flag) begin
            d.cnt = '0;
        end else if (q.cnt >= target) begin
            // held long enough: accept the new level
            d.flag = raw_quiet;
            d.cnt = '0;
        end else if (tick) begin
            d.cnt = q.cnt + DB_W'(1);
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign quiet = q.flag;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_NOISE_WAIT: assert property ($rose(q.flag) |->
        $past(raw_quiet) && $past(q.cnt) >= $past(debounce_halfms(noise_code)))
        else $error("quiet flag set before noise debounce ran out");
    AST_SIGNAL_WAIT: assert property ($fell(q.flag) |->
        !$past(raw_quiet) && $past(q.cnt) >= $past(debounce_halfms({2'b00, sig_code})))
        else $error("quiet flag cleared before signal debounce ran out");

endmodule

/* test/i2c_host_model.sv */
// host model driving the i2c control bus of the register bank
`timescale 1ns/1ps
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    // clock
    input wire logic mclk,
    // bus pins, sda_rel high releases the pulled-up line
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    logic ack_ok; // falls once any expected ack went missing
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        ack_ok = 1'b1;
    end
    // one bit: data set in low phase, sampled late in high phase
    task automatic bit_io(input logic b, output logic r);
        sda_rel <= b;
        repeat (4) @(posedge mclk);
        scl <= 1'b1;
        repeat (5) @(posedge mclk);
        r = sda_line;
        scl <= 1'b0;
        @(posedge mclk);
    endtask
    // start when first is high, stop otherwise; sda moves while scl is high
    task automatic edge_cond(input logic first);
        sda_rel <= first;
        repeat (4) @(posedge mclk);
        scl <= 1'b1;
        repeat (5) @(posedge mclk);
        sda_rel <= ~first;
        repeat (5) @(posedge mclk);
        if (first) begin
            scl <= 1'b0;
        end
        @(posedge mclk);
    endtask
    // eight bits msb first, ninth slot released
    task automatic byte_io(input logic [7:0] d, input logic chk, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, a);
        if (chk && a) begin
            ack_ok = 1'b0;
        end
    endtask
    // pointer byte then one data byte
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] q;
        edge_cond(1'b1);
        byte_io({DEV_ADDR, 1'b0}, 1'b1, q);
        byte_io(addr, 1'b1, q);
        byte_io(data, 1'b1, q);
        edge_cond(1'b0);
    endtask
    // pointer write, repeated start, one byte read and nacked
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        logic [7:0] q;
        edge_cond(1'b1);
        byte_io({DEV_ADDR, 1'b0}, 1'b1, q);
        byte_io(addr, 1'b1, q);
        edge_cond(1'b1);
        byte_io({DEV_ADDR, 1'b1}, 1'b1, q);
        byte_io(8'hFF, 1'b0, data);
        edge_cond(1'b0);
    endtask
endmodule

/* test/testbench.sv */
// register access tests for the agc flag and driver bank
`timescale 1ns/1ps
module testbench;
    import agc_regs_pkg::*;
    logic mclk, rst_n, scl, sda_rel, sda_o, sda_oe, sda_line, drm;
    logic ldp, rdp, sc_en, sc_lim, sc_off;
    logic [1:0] lmode;
    logic [2:0] rmode;
    logic [7:0] stat; // status inputs in flag bit order
    logic [7:0] rd;
    int error_cnt, checks_done;
    // open-drain line with pull-up
    assign sda_line = sda_rel & ~(sda_oe & ~sda_o);
    i2c_host_model i_host (.mclk(mclk), .scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
    agc_flag_driver_regs #(.HALF_MS_CYCLES(8)) i_agc_flag_driver_regs (
        .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .left_gain_settled(stat[7]), .left_adc_powered(stat[6]),
        .left_below_noise(stat[5]), .left_agc_at_max(stat[4]), .right_gain_settled(stat[3]),
        .right_adc_powered(stat[2]), .right_below_noise(stat[1]), .right_agc_at_max(stat[0]),
        .double_rate_mode(drm), .left_dac_power_en(ldp), .right_dac_power_en(rdp),
        .left_common_out_mode(lmode), .right_common_out_mode(rmode),
        .short_protect_en(sc_en), .short_current_limit(sc_lim), .short_auto_shutdown(sc_off));
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.reg_read(a, rd);
        check(rd, exp);
    endtask
    // watchdog against a hung bus
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        stat = 8'h00;
        drm = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        rchk(DEBOUNCE_OFF, 8'h00);
        rchk(DAC_OFF, 8'h00);
        rchk(HPD_OFF, 8'h00);
        // flags follow status while debounce lengths are zero
        foreach (stat[i]) begin
            stat <= i[0] ? 8'hA5 : 8'h5A;
            repeat (4) @(posedge mclk);
            rchk(FLAGS_OFF, i[0] ? 8'hA5 : 8'h5A);
        end
        i_host.reg_write(FLAGS_OFF, 8'h00);
        rchk(FLAGS_OFF, 8'h5A);
        i_host.reg_write(DAC_OFF, 8'hFF);
        rchk(DAC_OFF, 8'hF0);
        // every legal left common mode and dac power pairings 01, 10 and 11, reserved bits zero
        for (int m = 0; m < 3; m++) begin
            i_host.reg_write(DAC_OFF, {2'(m + 1), 2'(m), 4'h0});
            check({ldp, rdp, lmode, 4'h0}, {2'(m + 1), 2'(m), 4'h0});
        end
        // every legal right common mode, protection set to shut down
        for (int m = 0; m < 5; m++) begin
            i_host.reg_write(HPD_OFF, {2'b00, 3'(m), 3'b110});
            check({rmode, sc_en, sc_lim, sc_off, 2'b00}, {3'(m), 5'b10100});
        end
        i_host.reg_write(HPD_OFF, 8'h04);
        check({5'h00, sc_en, sc_lim, sc_off}, 8'h06);
        i_host.reg_write(HPD_OFF, 8'hFF);
        rchk(HPD_OFF, 8'h3E);
        i_host.reg_write(HPD_OFF, 8'h00);
        check({5'h00, sc_en, sc_lim, sc_off}, 8'h00);
        i_host.reg_write(8'h27, 8'hFF);
        rchk(8'h27, 8'h00);
        // noise code 9 is 2048 cycles, signal code 7 is 512 cycles
        stat <= 8'h00;
        i_host.reg_write(DEBOUNCE_OFF, 8'h4F);
        rchk(DEBOUNCE_OFF, 8'h4F);
        stat <= 8'h02;
        repeat (1200) @(posedge mclk);
        rchk(FLAGS_OFF, 8'h00);
        repeat (600) @(posedge mclk);
        rchk(FLAGS_OFF, 8'h02);
        stat <= 8'h00;
        repeat (100) @(posedge mclk);
        rchk(FLAGS_OFF, 8'h02);
        repeat (300) @(posedge mclk);
        rchk(FLAGS_OFF, 8'h00);
        // double rate halves the noise length to 1024 cycles
        drm <= 1'b1;
        stat <= 8'h02;
        repeat (1200) @(posedge mclk);
        rchk(FLAGS_OFF, 8'h02);
        check({7'h00, i_host.ack_ok}, 8'h01);
        give_verdict();
    end
endmodule
